// ---- include/bbrc_pkg.sv ----
// Shared constants, state type and helpers for the byte-bus read sequencer
package bbrc_pkg;

    // Address-space codes driven on the space_code lines
    localparam logic [2:0] SPACE_USER_DATA = 3'h1;
    localparam logic [2:0] SPACE_USER_PROG = 3'h2;
    localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
    localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
    localparam logic [2:0] SPACE_CPU = 3'h7;

    // Access sizes on the request port
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // Byte cycles per access size
    localparam logic [2:0] BYTES_BYTE = 3'h1;
    localparam logic [2:0] BYTES_WORD = 3'h2;
    localparam logic [2:0] BYTES_LONG = 3'h4;

    // Values after reset
    localparam logic [2:0] RST_SPACE = SPACE_USER_DATA;
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic RST_BUS_CLK = 1'b0;
    localparam logic RST_BYTE_MODE = 1'b1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Edges after reset release: the synchroniser shows the strap pin from the second edge on, so it is taken on the third
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // Half-clock states of one byte cycle, plus wait and fault tail states
    typedef enum logic [3:0] {
        BBRC_IDLE,
        BBRC_S0,
        BBRC_S1,
        BBRC_S2,
        BBRC_S3,
        BBRC_S4,
        BBRC_SW,
        BBRC_S5,
        BBRC_S6,
        BBRC_S7,
        BBRC_S8,
        BBRC_S9
    } bbrc_state_t;

    function automatic logic space_legal(input logic [2:0] code);
        space_legal = (code == SPACE_USER_DATA) || (code == SPACE_USER_PROG) ||
                      (code == SPACE_SUPV_DATA) || (code == SPACE_SUPV_PROG) ||
                      (code == SPACE_CPU);
    endfunction : space_legal

    function automatic logic [2:0] size_bytes(input logic [1:0] size);
        if (size == SIZE_LONG) begin
            size_bytes = BYTES_LONG;
        end else if (size == SIZE_WORD) begin
            size_bytes = BYTES_WORD;
        end else begin
            size_bytes = BYTES_BYTE;
        end
    endfunction : size_bytes

endpackage : bbrc_pkg

// ---- hdl/bbrc_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module bbrc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : bbrc_sync

// ---- hdl/bbrc_gather.sv ----
// Collects read bytes into one word, first byte most significant
`timescale 1ns/1ps
module bbrc_gather (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [7:0] byte_i,
    // Result
    output logic [31:0] word_o
);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_o <= bbrc_pkg::RST_WORD;
        end else if (clear_i) begin
            word_o <= bbrc_pkg::RST_WORD;
        end else if (load_i) begin
            word_o <= {word_o[23:0], byte_i};
        end
    end

endmodule : bbrc_gather

// ---- hdl/bbrc_read_cycle.sv ----
// Byte-bus master: sequences read cycles of one, two or four bytes
`timescale 1ns/1ps
module bbrc_read_cycle #(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Request port
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_size_i,
    input wire logic [2:0] req_space_i,
    // Answer port
    output logic resp_valid_o,
    output logic [31:0] resp_data_o,
    output logic resp_fault_o,
    output logic resp_sync_o,
    // Bus outputs
    output logic bus_clk_o,
    output logic [2:0] space_code_o,
    output logic [ADDR_W-1:0] address_o,
    output logic address_oe_o,
    output logic read_write_o,
    output logic address_strobe_n_o,
    output logic lower_byte_strobe_n_o,
    output logic upper_byte_strobe_n_o,
    output logic byte_mode_o,
    // Bus inputs
    input wire logic [7:0] data_i,
    input wire logic transfer_ack_n_i,
    input wire logic bus_fault_in_n_i,
    input wire logic sync_peripheral_select_n_i,
    input wire logic width_select_i
);

    bbrc_pkg::bbrc_state_t st_q, st_d;
    logic [11:0] pins_s;
    logic [7:0] data_s;
    logic ack_s, fault_s, vpa_s, width_s;
    logic [1:0] strap_cnt_q;
    logic [2:0] left_q, left_d;
    logic fault_q, fault_d, sync_q, sync_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [2:0] space_d;
    logic [31:0] word_w;

    // Pins come from another timing domain: two flops before use
    bbrc_sync #(
        .W(12),
        .RST_VAL(12'hf00)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({width_select_i, sync_peripheral_select_n_i, bus_fault_in_n_i, transfer_ack_n_i, data_i}),
        .sync_o(pins_s)
    );

    assign data_s = pins_s[7:0];
    assign ack_s = !pins_s[8];
    assign fault_s = !pins_s[9];
    assign vpa_s = !pins_s[10];
    assign width_s = pins_s[11];

    wire accept_w = req_valid_i && req_ready_o;
    wire legal_w = bbrc_pkg::space_legal(req_space_i);
    wire serve_w = accept_w && legal_w && byte_mode_o;
    wire term_w = ack_s || fault_s;
    wire lone_fault_w = fault_s && !ack_s;
    wire capture_w = (st_q == bbrc_pkg::BBRC_S6) && !fault_q && !sync_q;
    wire more_w = (left_q > 3'h1) && !fault_q && !sync_q;

    always_comb begin
        st_d = st_q;
        left_d = left_q;
        fault_d = fault_q;
        sync_d = sync_q;
        addr_d = addr_q;
        space_d = space_code_o;
        case (st_q)
            bbrc_pkg::BBRC_IDLE: begin
                if (serve_w) begin
                    st_d = bbrc_pkg::BBRC_S0;
                    left_d = bbrc_pkg::size_bytes(req_size_i);
                    addr_d = req_addr_i;
                    space_d = req_space_i;
                    fault_d = 1'b0;
                    sync_d = 1'b0;
                end
            end
            bbrc_pkg::BBRC_S0: st_d = bbrc_pkg::BBRC_S1;
            bbrc_pkg::BBRC_S1: st_d = bbrc_pkg::BBRC_S2;
            bbrc_pkg::BBRC_S2: st_d = bbrc_pkg::BBRC_S3;
            bbrc_pkg::BBRC_S3: st_d = bbrc_pkg::BBRC_S4;
            bbrc_pkg::BBRC_S4: begin
                // Falling edge ending state 4 samples every terminator
                if (term_w) begin
                    st_d = bbrc_pkg::BBRC_S5;
                    fault_d = lone_fault_w;
                end else if (vpa_s) begin
                    st_d = bbrc_pkg::BBRC_S7;
                    sync_d = 1'b1;
                end else begin
                    st_d = bbrc_pkg::BBRC_SW;
                end
            end
            bbrc_pkg::BBRC_SW: st_d = bbrc_pkg::BBRC_S4;
            bbrc_pkg::BBRC_S5: st_d = bbrc_pkg::BBRC_S6;
            bbrc_pkg::BBRC_S6: begin
                st_d = bbrc_pkg::BBRC_S7;
                fault_d = fault_q || lone_fault_w;
            end
            bbrc_pkg::BBRC_S7: begin
                // Fault stretches the cycle one clock; remaining bytes are dropped
                if (fault_q) begin
                    st_d = bbrc_pkg::BBRC_S8;
                end else if (more_w) begin
                    st_d = bbrc_pkg::BBRC_S0;
                    left_d = left_q - 3'h1;
                    addr_d = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                end else begin
                    st_d = bbrc_pkg::BBRC_IDLE;
                end
            end
            bbrc_pkg::BBRC_S8: st_d = bbrc_pkg::BBRC_S9;
            bbrc_pkg::BBRC_S9: st_d = bbrc_pkg::BBRC_IDLE;
            default: st_d = bbrc_pkg::BBRC_IDLE;
        endcase
    end

    // Even states start on a rising bus clock, odd ones on a falling edge
    wire strobe_on_w = (st_d == bbrc_pkg::BBRC_S2) ||
                       (!address_strobe_n_o && (st_d != bbrc_pkg::BBRC_S7) &&
                        (st_d != bbrc_pkg::BBRC_S8) && (st_d != bbrc_pkg::BBRC_IDLE) &&
                        (st_d != bbrc_pkg::BBRC_S0));
    wire oe_d = (st_d == bbrc_pkg::BBRC_S1) ||
                (address_oe_o && (st_q != bbrc_pkg::BBRC_S7) && (st_d != bbrc_pkg::BBRC_IDLE));
    wire done_d = ((st_q == bbrc_pkg::BBRC_S7) && !fault_q && !more_w) || (st_q == bbrc_pkg::BBRC_S9);
    wire reject_d = accept_w && !serve_w;
    // Requests wait for the width strap, so no access runs in a mode taken from reset values
    wire ready_d = (st_d == bbrc_pkg::BBRC_IDLE) && bus_clk_o && (strap_cnt_q == bbrc_pkg::STRAP_DONE);

    bbrc_gather u_gather (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(serve_w),
        .load_i(capture_w),
        .byte_i(data_s),
        .word_o(word_w)
    );

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= bbrc_pkg::BBRC_IDLE;
            left_q <= 3'h0;
            fault_q <= 1'b0;
            sync_q <= 1'b0;
            addr_q <= '0;
        end else begin
            st_q <= st_d;
            left_q <= left_d;
            fault_q <= fault_d;
            sync_q <= sync_d;
            addr_q <= addr_d;
        end
    end

    // Bus pins; all but the bus clock hold in states 3 and 5 since nothing changes there
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_clk_o <= bbrc_pkg::RST_BUS_CLK;
            space_code_o <= bbrc_pkg::RST_SPACE;
            address_o <= '0;
            address_oe_o <= 1'b0;
            read_write_o <= 1'b1;
            address_strobe_n_o <= bbrc_pkg::RST_STROBE_N;
            lower_byte_strobe_n_o <= bbrc_pkg::RST_STROBE_N;
            upper_byte_strobe_n_o <= bbrc_pkg::RST_STROBE_N;
        end else begin
            bus_clk_o <= !bus_clk_o;
            space_code_o <= space_d;
            address_o <= (st_d == bbrc_pkg::BBRC_S1) ? addr_q : address_o;
            address_oe_o <= oe_d;
            read_write_o <= 1'b1;
            address_strobe_n_o <= !strobe_on_w;
            lower_byte_strobe_n_o <= !strobe_on_w;
            upper_byte_strobe_n_o <= bbrc_pkg::RST_STROBE_N;
        end
    end

    // Answer port
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
            resp_valid_o <= 1'b0;
            resp_data_o <= bbrc_pkg::RST_WORD;
            resp_fault_o <= 1'b0;
            resp_sync_o <= 1'b0;
        end else begin
            req_ready_o <= ready_d;
            resp_valid_o <= done_d || reject_d;
            resp_data_o <= reject_d ? bbrc_pkg::RST_WORD : word_w;
            resp_fault_o <= reject_d || (done_d && fault_q);
            resp_sync_o <= done_d && sync_q;
        end
    end

    // Width select is a strap: read once the synchroniser holds the pin rather than its reset value
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_cnt_q <= 2'h0;
            byte_mode_o <= bbrc_pkg::RST_BYTE_MODE;
        end else if (strap_cnt_q != bbrc_pkg::STRAP_DONE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == bbrc_pkg::STRAP_TAKE) begin
                byte_mode_o <= !width_s;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    space_stable_a: assert property (!address_strobe_n_o && $past(!address_strobe_n_o) |-> $stable(space_code_o))
        else $error("space code moved while address strobe asserted");
    space_legal_a: assert property (!address_strobe_n_o |-> bbrc_pkg::space_legal(space_code_o))
        else $error("reserved space code on bus");
    upper_negated_a: assert property (byte_mode_o |-> upper_byte_strobe_n_o)
        else $error("upper strobe asserted in byte mode");
    strobe_after_addr_a: assert property ($fell(address_strobe_n_o) |-> address_oe_o && $past(address_oe_o) &&
                                          bus_clk_o && !lower_byte_strobe_n_o && read_write_o)
        else $error("strobes asserted without stable address");
    // A converted cycle drops its strobes early, so only the first three samples are firm
    strobe_length_a: assert property ($fell(address_strobe_n_o) |-> !address_strobe_n_o[*3] ##1
                                      (sync_q or !address_strobe_n_o[*2]))
        else $error("strobe shorter than states 2 to 6");
    quiet_s3_a: assert property ((st_q == bbrc_pkg::BBRC_S3 || st_q == bbrc_pkg::BBRC_S5) |=>
                                  $stable(address_o) && $stable(address_strobe_n_o) &&
                                  $stable(space_code_o) && $stable(address_oe_o) && $stable(lower_byte_strobe_n_o))
        else $error("bus output changed in state 3 or 5");
    wait_insert_a: assert property (st_q == bbrc_pkg::BBRC_S4 && !ack_s && !fault_s && !vpa_s |=>
                                     st_q == bbrc_pkg::BBRC_SW ##1 st_q == bbrc_pkg::BBRC_S4)
        else $error("no whole-clock wait state inserted");
    sync_convert_a: assert property (st_q == bbrc_pkg::BBRC_S4 && !ack_s && !fault_s && vpa_s |=>
                                      st_q == bbrc_pkg::BBRC_S7 ##1 address_strobe_n_o)
        else $error("peripheral select did not convert the cycle");
    data_capture_a: assert property (capture_w |=> word_w[7:0] == $past(data_s) ##1
                                      address_strobe_n_o)
        else $error("byte not captured at end of state 6");
    addr_release_a: assert property (st_q == bbrc_pkg::BBRC_S7 |=> !address_oe_o ##1
                                     (!address_oe_o || st_q == bbrc_pkg::BBRC_S1))
        else $error("address not released after state 7");
    fault_tail_a: assert property (st_q == bbrc_pkg::BBRC_S7 && fault_q |=>
                                    st_q == bbrc_pkg::BBRC_S8 ##1 st_q == bbrc_pkg::BBRC_S9 ##1 resp_fault_o)
        else $error("faulted cycle did not end in state 9");
    lone_fault_a: assert property (st_q == bbrc_pkg::BBRC_S4 && lone_fault_w |=>
                                    st_q == bbrc_pkg::BBRC_S5 && fault_q)
        else $error("lone bus fault not recorded at end of state 4");
    addr_valid_a: assert property (st_q == bbrc_pkg::BBRC_S1 |-> address_oe_o && address_o == addr_q)
        else $error("address not valid in state 1");
    read_line_a: assert property (st_q == bbrc_pkg::BBRC_S0 |->
                                  read_write_o && bbrc_pkg::space_legal(space_code_o))
        else $error("state 0 without read line or space code");
    strobe_release_a: assert property (st_q == bbrc_pkg::BBRC_S6 |=>
                                       address_strobe_n_o && lower_byte_strobe_n_o)
        else $error("strobes not negated entering state 7");

    // Request port and strap
    request_refuse_a: assert property (accept_w && !serve_w |=>
                                       resp_valid_o && resp_fault_o && st_q == bbrc_pkg::BBRC_IDLE)
        else $error("refused request not answered with a fault");
    answer_pulse_a: assert property (resp_valid_o |=> !resp_valid_o)
        else $error("answer stood longer than one cycle");
    ready_idle_a: assert property (req_ready_o |-> st_q == bbrc_pkg::BBRC_IDLE && !bus_clk_o)
        else $error("ready offered outside idle or on a high bus clock");
    strap_hold_a: assert property (strap_cnt_q == bbrc_pkg::STRAP_DONE |=> $stable(byte_mode_o))
        else $error("bus width changed after the strap was read");

    word_read_c: cover property (serve_w && req_size_i == bbrc_pkg::SIZE_WORD ##[20:200] resp_valid_o);
    wait_seen_c: cover property (st_q == bbrc_pkg::BBRC_SW);
    fault_seen_c: cover property (st_q == bbrc_pkg::BBRC_S9);
    sync_seen_c: cover property (resp_sync_o);
    refuse_seen_c: cover property (accept_w && !serve_w);

endmodule : bbrc_read_cycle

// ---- verification/bbrc_mem_model.sv ----
// Behavioural memory that answers byte read cycles
`timescale 1ns/1ps
module bbrc_mem_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Behaviour: 0 acknowledge, 1 bus fault, 2 peripheral select
    input wire logic [1:0] mode_i,
    input wire logic [3:0] delay_i,
    // Bus side
    input wire logic [19:0] address_i,
    input wire logic byte_strobe_n_i,
    output logic [7:0] data_o,
    output logic transfer_ack_n_o,
    output logic bus_fault_in_n_o,
    output logic sync_peripheral_select_n_o
);
    logic [3:0] wait_q;
    logic [7:0] last_q;
    logic sel;
    logic late;
    assign sel = !byte_strobe_n_i;
    assign late = sel && (wait_q >= delay_i);
    // Released lines show the inverse of the last byte so a stale value never passes
    assign data_o = sel ? (address_i[7:0] ^ 8'ha5) : ~last_q;
    // Terminators have pull-ups and rise as soon as the strobe is gone
    assign transfer_ack_n_o = !(late && mode_i == 2'h0);
    assign bus_fault_in_n_o = !(late && mode_i == 2'h1);
    assign sync_peripheral_select_n_o = !(late && mode_i == 2'h2);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 4'h0;
            last_q <= 8'h00;
        end else begin
            wait_q <= sel ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
            last_q <= sel ? data_o : last_q;
        end
    end
endmodule : bbrc_mem_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the byte-bus read sequencer
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [19:0] req_addr_i = 20'h0;
    logic [1:0] req_size_i = 2'h0;
    logic [2:0] req_space_i = 3'h1;
    logic width_select_i = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] delay = 4'h0;
    logic req_ready_o, resp_valid_o, resp_fault_o, resp_sync_o, bus_clk_o, address_oe_o, read_write_o;
    logic address_strobe_n_o, lower_byte_strobe_n_o, upper_byte_strobe_n_o, byte_mode_o;
    logic transfer_ack_n_i, bus_fault_in_n_i, sync_peripheral_select_n_i;
    logic [31:0] resp_data_o;
    logic [2:0] space_code_o;
    logic [19:0] address_o;
    logic [7:0] data_i;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int lat;
    logic [2:0] exp_space;
    logic [31:0] got_data;
    logic got_valid, got_fault, got_sync;
    logic [19:0] addr_q[$];
    logic strobe_prev = 1'b1;

    bbrc_read_cycle #(.ADDR_W(20)) u_bbrc_read_cycle (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_addr_i(req_addr_i),
        .req_size_i(req_size_i), .req_space_i(req_space_i), .resp_valid_o(resp_valid_o),
        .resp_data_o(resp_data_o), .resp_fault_o(resp_fault_o), .resp_sync_o(resp_sync_o),
        .bus_clk_o(bus_clk_o), .space_code_o(space_code_o), .address_o(address_o),
        .address_oe_o(address_oe_o), .read_write_o(read_write_o), .address_strobe_n_o(address_strobe_n_o),
        .lower_byte_strobe_n_o(lower_byte_strobe_n_o), .upper_byte_strobe_n_o(upper_byte_strobe_n_o),
        .byte_mode_o(byte_mode_o), .data_i(data_i), .transfer_ack_n_i(transfer_ack_n_i),
        .bus_fault_in_n_i(bus_fault_in_n_i), .sync_peripheral_select_n_i(sync_peripheral_select_n_i),
        .width_select_i(width_select_i));

    bbrc_mem_model u_bbrc_mem_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mode_i(mode),
        .delay_i(delay), .address_i(address_o), .byte_strobe_n_i(lower_byte_strobe_n_o), .data_o(data_i),
        .transfer_ack_n_o(transfer_ack_n_i), .bus_fault_in_n_o(bus_fault_in_n_i),
        .sync_peripheral_select_n_o(sync_peripheral_select_n_i));

    always #50 ref_clk_i = ~ref_clk_i;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    // Watch the pins while a strobe is out
    always @(negedge address_strobe_n_o) begin
        addr_q.push_back(address_o);
    end
    always @(negedge ref_clk_i) begin
        if (address_strobe_n_o === 1'b0 && strobe_prev === 1'b1) begin
            check("bus_clk_s2", {31'h0, bus_clk_o}, 32'h1);
        end
        strobe_prev = address_strobe_n_o;
        if (address_strobe_n_o === 1'b0) begin
            check("space_held", {29'h0, space_code_o}, {29'h0, exp_space});
            check("addr_stable", {12'h0, address_o}, {12'h0, addr_q[$]});
            check("addr_driven", {31'h0, address_oe_o}, 32'h1);
            check("read_line", {31'h0, read_write_o}, 32'h1);
            check("byte_strobe", {31'h0, lower_byte_strobe_n_o}, 32'h0);
            check("upper_strobe", {31'h0, upper_byte_strobe_n_o}, 32'h1);
        end
    end

    function automatic logic [31:0] exp_word(input logic [19:0] a, input int n);
        exp_word = 32'h0;
        for (int i = 0; i < n; i++) begin
            exp_word = {exp_word[23:0], a[7:0] + 8'(i) ^ 8'ha5};
        end
    endfunction : exp_word

    task automatic do_read(input logic [19:0] a, input logic [1:0] size, input logic [2:0] space);
        @(negedge ref_clk_i);
        addr_q.delete();
        exp_space = space;
        req_addr_i = a;
        req_size_i = size;
        req_space_i = space;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        lat = 1;
        while (resp_valid_o !== 1'b1 && lat < 200) begin
            @(negedge ref_clk_i);
            lat++;
        end
        got_valid = resp_valid_o;
        got_data = resp_data_o;
        got_fault = resp_fault_o;
        got_sync = resp_sync_o;
    endtask : do_read

    task automatic t_sizes;
        logic [19:0] a;
        int n;
        mode = 2'h0;
        delay = 4'h0;
        for (int s = 0; s < 3; s++) begin
            n = (s == 0) ? 1 : 2 * s;
            a = 20'h1_00fd + 20'(s);
            do_read(a, 2'(s), bbrc_pkg::SPACE_SUPV_PROG);
            check("latency", lat, 1 + 8 * n);
            check("data", got_data, exp_word(a, n));
            check("fault", {31'h0, got_fault}, 32'h0);
            check("bytes", addr_q.size(), n);
            for (int i = 0; i < n && i < addr_q.size(); i++) begin
                check("byte_addr", {12'h0, addr_q[i]}, {12'h0, a + 20'(i)});
            end
        end
    endtask : t_sizes

    task automatic t_wait;
        mode = 2'h0;
        delay = 4'h6;
        do_read(20'h0_2468, bbrc_pkg::SIZE_LONG, bbrc_pkg::SPACE_USER_PROG);
        check("wait_data", got_data, exp_word(20'h0_2468, 4));
        check("wait_len", {31'h0, lat > 33 && lat % 2 == 1}, 32'h1);
    endtask : t_wait

    task automatic t_fault;
        mode = 2'h1;
        delay = 4'h0;
        do_read(20'h0_0040, bbrc_pkg::SIZE_WORD, bbrc_pkg::SPACE_SUPV_DATA);
        check("fault_len", lat, 11);
        check("fault_flag", {31'h0, got_fault}, 32'h1);
        check("fault_bytes", addr_q.size(), 1);
    endtask : t_fault

    task automatic t_sync;
        mode = 2'h2;
        do_read(20'h0_0080, bbrc_pkg::SIZE_BYTE, bbrc_pkg::SPACE_CPU);
        check("sync_done", {31'h0, got_valid}, 32'h1);
        check("sync_flag", {31'h0, got_sync}, 32'h1);
        check("sync_len", lat, 7);
        check("sync_fault", {31'h0, got_fault}, 32'h0);
    endtask : t_sync

    task automatic t_spaces;
        logic bad;
        mode = 2'h0;
        for (int c = 0; c < 8; c++) begin
            bad = (c == 0) || (c == 3) || (c == 4);
            do_read(20'h0_0010, bbrc_pkg::SIZE_BYTE, 3'(c));
            check("space_fault", {31'h0, got_fault}, {31'h0, bad});
            check("space_len", lat, bad ? 1 : 9);
            check("space_bus", addr_q.size(), bad ? 0 : 1);
        end
    endtask : t_spaces

    // Mid-run resets with the strap high, then low again
    task automatic t_wide;
        width_select_i = 1'b1;
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        check("wide_mode", {31'h0, byte_mode_o}, 32'h0);
        do_read(20'h0_0020, bbrc_pkg::SIZE_BYTE, bbrc_pkg::SPACE_USER_DATA);
        check("wide_refused", {31'h0, got_fault}, 32'h1);
        check("wide_len", lat, 1);
        check("wide_bus", addr_q.size(), 0);
        width_select_i = 1'b0;
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        check("byte_again", {31'h0, byte_mode_o}, 32'h1);
        do_read(20'h0_0031, bbrc_pkg::SIZE_BYTE, bbrc_pkg::SPACE_USER_DATA);
        check("byte_again_data", got_data, exp_word(20'h0_0031, 1));
    endtask : t_wide

    initial begin
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check("byte_mode", {31'h0, byte_mode_o}, 32'h1);
        check("upper_idle", {31'h0, upper_byte_strobe_n_o}, 32'h1);
        t_sizes();
        t_wait();
        t_fault();
        t_sync();
        t_spaces();
        t_wide();
        stop_test();
    end
endmodule : tb_top
